// File: bench/core_model.sv
// Behavioural core that takes vectored requests and acknowledges them
`timescale 1ns/100ps
`default_nettype none
module core_model
  import irq_slots_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request side
  input  wire logic       vector_request,
  input  wire vector_t    vector_out,
  // Behaviour knobs: cycles before acknowledge, or never acknowledge
  input  wire logic [3:0] ack_delay,
  input  wire logic       hold_ack,
  // Acknowledge and the vector taken with it
  output logic            vector_ack,
  output vector_t         taken_vec
);
  logic [3:0] wait_cnt;  // Cycles the current request has waited

  // Acknowledge only a presented request, one cycle wide, after the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_ack <= 1'b0;
      wait_cnt   <= 4'h0;
      taken_vec  <= '0;
    end else begin
      vector_ack <= vector_request && !vector_ack && !hold_ack && wait_cnt == ack_delay;
      wait_cnt   <= (vector_request && !vector_ack) ? wait_cnt + 4'h1 : 4'h0;
      // Vector is taken at the edge where acknowledge meets the request
      if (vector_ack && vector_request) begin
        taken_vec <= vector_out;
      end
    end
  end
endmodule : core_model
`default_nettype wire

// File: bench/irq_source_config_slots_tb_top.sv
// Self-checking bench for the interrupt source slots
`timescale 1ns/100ps
`default_nettype none
module irq_source_config_slots_tb_top;
  import irq_slots_pkg::*;
  // Bus, source and core signals
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [ADDR_W-1:0]    paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [NUM_SLOTS-1:0] hw_source;
  logic                 vector_ack, fast_interrupt_line, vector_request, irq, hold_ack;
  logic [3:0]           ack_delay;
  vector_t              vector_out, taken_vec;
  int                   err_count, n_compared;

  irq_source_config_slots u_irq_source_config_slots (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .hw_source(hw_source),
    .vector_ack(vector_ack), .fast_interrupt_line(fast_interrupt_line),
    .vector_request(vector_request), .vector_out(vector_out), .irq(irq));
  core_model u_core_model (.pclk(pclk), .presetn(presetn), .vector_request(vector_request),
    .vector_out(vector_out), .ack_delay(ack_delay), .hold_ack(hold_ack),
    .vector_ack(vector_ack), .taken_vec(taken_vec));

  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Compare one result and count it
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog bounds this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Wait, bounded, for a presented vector
  task automatic wait_vreq;
    int n;
    n = 0;
    while (vector_request !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check("vector_request", 32'h1, vector_request);
  endtask : wait_vreq

  // Verdict and end of run
  task automatic complete_run;
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Watchdog against a hang
  initial begin
    #(40 * 20000);
    err_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, hold_ack, last_err} = '0;
    paddr = '0;
    pwdata = '0;
    rd = '0;
    hw_source = '0;
    ack_delay = 4'h2;
    err_count = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    apb(1'b0, SLOT39_BASE, 32'h0); check("slot39", 32'h0, rd);
    apb(1'b0, SLOT83_BASE, 32'h0); check("slot83", 32'h0, rd);
    apb(1'b0, MASK_ADDR, 32'h0); check("mask", 32'h0, rd);
    check("pready", 32'h1, pready);
    // Reserved bits and aliases, enable kept low while the level moves
    apb(1'b1, SLOT39_BASE, 32'h00000003);
    apb(1'b0, SLOT39_BASE, 32'h0); check("reserved", 32'h00000003, rd);
    apb(1'b1, SLOT39_BASE + 12'h004, 32'h00000008);
    apb(1'b0, SLOT39_BASE + 12'h004, 32'h0); check("set", 32'h0000000B, rd);
    apb(1'b1, SLOT39_BASE + 12'h008, 32'h00000001);
    apb(1'b0, SLOT39_BASE + 12'h008, 32'h0); check("clr", 32'h0000000A, rd);
    apb(1'b1, SLOT39_BASE + 12'h00C, 32'h00000003);
    apb(1'b0, SLOT39_BASE + 12'h00C, 32'h0); check("tog", 32'h00000009, rd);
    apb(1'b1, SLOT39_BASE, 32'h0);
    apb(1'b0, 12'h3A0, 32'h0); check("unmapped err", 32'h1, last_err);
    apb(1'b1, 12'h3A0, 32'h00000001); check("unmapped wr err", 32'h1, last_err);
    // Fast steered source
    hw_source <= 2'h2;
    apb(1'b1, SLOT83_BASE, 32'h00000014);
    repeat (2) @(posedge pclk);
    check("fast line", 32'h1, fast_interrupt_line);
    check("no vector", 32'h0, vector_request);
    // Same source through the vectored path, acknowledged by the core
    apb(1'b1, SLOT83_BASE + 12'h008, 32'h00000010);
    wait_vreq();
    check("vector", 32'h4, vector_out);
    repeat (6) @(posedge pclk);
    check("taken", 32'h4, taken_vec);
    check("fast off", 32'h0, fast_interrupt_line);
    hw_source <= 2'h0;
    apb(1'b1, SLOT83_BASE, 32'h0);
    // Software request, gated by enable
    apb(1'b1, SLOT39_BASE, 32'h00000009);
    repeat (3) @(posedge pclk);
    check("gated", 32'h0, vector_request);
    apb(1'b1, SLOT39_BASE + 12'h004, 32'h00000004);
    wait_vreq();
    check("soft vector", 32'h1, vector_out);
    apb(1'b1, SLOT39_BASE + 12'h008, 32'h00000008);
    repeat (3) @(posedge pclk);
    check("withdrawn", 32'h0, vector_request);
    apb(1'b1, SLOT39_BASE + 12'h008, 32'h00000004);
    // Every level of slot83 against slot39 at level 2
    hold_ack <= 1'b1;
    apb(1'b1, SLOT39_BASE, 32'h0000000A);
    apb(1'b1, SLOT39_BASE + 12'h004, 32'h00000004);
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, SLOT83_BASE, 32'h00000008 | l);
      apb(1'b1, SLOT83_BASE + 12'h004, 32'h00000004);
      repeat (2) @(posedge pclk);
      check("winner", (l > 2) ? 32'h7 : 32'h2, vector_out);
      apb(1'b1, SLOT83_BASE + 12'h008, 32'h00000004);
    end
    apb(1'b1, SLOT83_BASE, 32'h0);
    apb(1'b1, SLOT39_BASE + 12'h008, 32'h00000004);
    apb(1'b1, SLOT39_BASE, 32'h0);
    // Event status, mask and interrupt output
    apb(1'b1, STATUS_ADDR, 32'h00000007);
    apb(1'b1, SLOT39_BASE, 32'h0000000C);
    apb(1'b0, STATUS_ADDR, 32'h0); check("status", 32'h1, rd);
    check("irq masked", 32'h0, irq);
    apb(1'b1, MASK_ADDR, 32'h00000001);
    repeat (2) @(posedge pclk);
    check("irq on", 32'h1, irq);
    apb(1'b1, STATUS_ADDR, 32'h00000001);
    repeat (2) @(posedge pclk);
    check("irq off", 32'h0, irq);
    apb(1'b0, STATUS_ADDR, 32'h0); check("status clr", 32'h0, rd);
    complete_run();
  end
endmodule : irq_source_config_slots_tb_top
`default_nettype wire

// File: rtl/irq_level_pick.sv
// Picks the strongest level among vectored candidate sources
`timescale 1ns/100ps
`default_nettype none
module irq_level_pick
  import irq_slots_pkg::*;
(
  // Candidates
  input  wire logic [NUM_SLOTS-1:0] cand,
  input  wire slot_cfg_t            cfg [NUM_SLOTS],
  // Result
  output logic                      any,
  output vector_t                   winner
);

  // Scan upward; only a strictly stronger level displaces, so ties go low
  always_comb begin
    any    = 1'b0;
    winner = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (cand[i] && (!any || cfg[i].level > winner.level)) begin
        any           = 1'b1;
        winner.source = i[0];
        winner.level  = cfg[i].level;
      end
    end
  end

endmodule : irq_level_pick
`default_nettype wire

// File: rtl/irq_slots_pkg.sv
// Constants, field layouts and types shared by the interrupt source slot block
package irq_slots_pkg;

  // Slot count and bus address width
  localparam int          NUM_SLOTS   = 2;
  localparam int          ADDR_W      = 12;

  // Slot base byte addresses
  localparam logic [11:0] SLOT39_BASE = 12'h390;
  localparam logic [11:0] SLOT83_BASE = 12'h650;

  // Event status and mask registers
  localparam logic [11:0] STATUS_ADDR = 12'h700;
  localparam logic [11:0] MASK_ADDR   = 12'h704;

  // Alias selector, address bits 3:2
  localparam logic [1:0]  ALIAS_BASE  = 2'h0;
  localparam logic [1:0]  ALIAS_SET   = 2'h1;
  localparam logic [1:0]  ALIAS_CLR   = 2'h2;
  localparam logic [1:0]  ALIAS_TOG   = 2'h3;

  // Slot field layout
  localparam int          CFG_W       = 5;
  localparam logic [4:0]  CFG_RESET   = 5'h00;
  localparam logic [1:0]  LEVEL_WEAK  = 2'h0;
  localparam logic [1:0]  LEVEL_STRONG = 2'h3;

  // Status layout: one pending event per slot, then acknowledge event
  localparam int          STATUS_W    = 3;
  localparam int          EVT_ACK_BIT = 2;
  localparam logic [2:0]  STATUS_RESET = 3'h0;
  localparam logic [2:0]  MASK_RESET  = 3'h0;

  // Zero pad above narrow read data
  localparam logic [26:0] PAD_CFG     = 27'h0000000;
  localparam logic [28:0] PAD_STATUS  = 29'h00000000;

  // One slot, bit order as stored
  typedef struct packed {
    logic       fast_steer;
    logic       software_request;
    logic       enable;
    logic [1:0] level;
  } slot_cfg_t;

  // Vector presented to the core
  typedef struct packed {
    logic       source;
    logic [1:0] level;
  } vector_t;

  // Vectored request sequencer
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_PRESENT = 3'h2,
    ST_ACKED   = 3'h4
  } vec_state_t;

endpackage : irq_slots_pkg

// File: rtl/irq_source_config_slots.sv
// Interrupt source slots with APB access, fast line and vectored request
`timescale 1ns/100ps
`default_nettype none
module irq_source_config_slots
  import irq_slots_pkg::*;
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Hardware interrupt sources
  input  wire logic [NUM_SLOTS-1:0] hw_source,
  // Core side
  input  wire logic                 vector_ack,
  output logic                      fast_interrupt_line,
  output logic                      vector_request,
  output vector_t                   vector_out,
  // Block event interrupt
  output logic                      irq
);

  // Slot base table, index order matches hw_source
  localparam logic [11:0] SLOT_BASE [NUM_SLOTS] = '{SLOT39_BASE, SLOT83_BASE};

  // Bus phases
  wire logic setup  = psel & ~penable;
  wire logic access = psel & penable;
  wire logic wr     = access & pwrite;

  // Alias selector
  wire logic [1:0] alias_sel = paddr[3:2];

  // Slot state and decode
  slot_cfg_t            cfg      [NUM_SLOTS];  // Stored slots
  slot_cfg_t            next_cfg [NUM_SLOTS];  // Value after a write
  logic [NUM_SLOTS-1:0] hit_slot;              // Address lands in slot window
  logic [NUM_SLOTS-1:0] pend;                  // Gated request per source
  logic [NUM_SLOTS-1:0] pend_q;                // Previous pend, for events
  logic [NUM_SLOTS-1:0] fast_cand;             // Pending and fast steered
  logic [NUM_SLOTS-1:0] vec_cand;              // Pending and vectored

  // Per-slot decode, alias arithmetic and request gating
  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    wire logic [CFG_W-1:0] cur = cfg[i];
    wire logic [CFG_W-1:0] wd  = pwdata[CFG_W-1:0];

    // Window of four words: base, set, clear, toggle
    assign hit_slot[i] = (paddr[11:4] == SLOT_BASE[i][11:4]);

    // Alias operations on written ones
    always_comb begin
      case (alias_sel)
        ALIAS_SET: next_cfg[i] = cur | wd;
        ALIAS_CLR: next_cfg[i] = cur & ~wd;
        ALIAS_TOG: next_cfg[i] = cur ^ wd;
        default:   next_cfg[i] = wd;
      endcase
    end

    // Slot storage; write lands at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg[i] <= CFG_RESET;
      end else if (wr && hit_slot[i]) begin
        cfg[i] <= next_cfg[i];
      end
    end

    // Forced or hardware request, passed only when enabled
    assign pend[i] = (hw_source[i] | cfg[i].software_request)
                     & cfg[i].enable;

    // Steering split between the two lines
    assign fast_cand[i] = pend[i] & cfg[i].fast_steer;
    assign vec_cand[i]  = pend[i] & ~cfg[i].fast_steer;
  end

  // Block register decode
  wire logic hit_status = (paddr == STATUS_ADDR);
  wire logic hit_mask   = (paddr == MASK_ADDR);
  wire logic map_hit    = (|hit_slot) | hit_status | hit_mask;

  // Zero-wait slave; unmapped access flagged in the access phase
  assign pready  = 1'b1;
  assign pslverr = access & ~map_hit;

  // Read mux; reserved upper bits always zero
  logic [31:0] read_val;
  logic [STATUS_W-1:0] status;  // Sticky events
  logic [STATUS_W-1:0] mask;    // Event enables
  always_comb begin
    read_val = 32'h00000000;
    if (hit_status) begin
      read_val = {PAD_STATUS, status};
    end else if (hit_mask) begin
      read_val = {PAD_STATUS, mask};
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (hit_slot[i]) begin
          read_val = {PAD_CFG, cfg[i]};
        end
      end
    end
  end

  // Read data captured in the setup phase, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= read_val;
    end
  end

  // Strongest vectored candidate
  logic    vec_any;     // At least one vectored candidate
  vector_t vec_winner;  // Its source and level
  irq_level_pick u_pick (
    .cand   (vec_cand),
    .cfg    (cfg),
    .any    (vec_any),
    .winner (vec_winner)
  );

  // Vectored request sequencer
  vec_state_t state;       // Current state
  vec_state_t next_state;  // Following state
  always_comb begin
    case (state)
      ST_IDLE:    next_state = vec_any ? ST_PRESENT : ST_IDLE;
      ST_PRESENT: begin
        if (vector_ack) begin
          next_state = ST_ACKED;
        end else if (!vec_any) begin
          next_state = ST_IDLE;  // Withdrawn before service
        end else begin
          next_state = ST_PRESENT;
        end
      end
      ST_ACKED:   next_state = ST_IDLE;  // First of two quiet cycles after service
      default:    next_state = ST_IDLE;
    endcase
  end

  // State register and vector; vector follows the winner while presented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      vector_out <= '0;
    end else begin
      state <= next_state;
      if (next_state == ST_PRESENT) begin
        vector_out <= vec_winner;
      end
    end
  end
  assign vector_request = (state == ST_PRESENT);

  // Fast line, registered, bypasses the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_interrupt_line <= 1'b0;
    end else begin
      fast_interrupt_line <= |fast_cand;
    end
  end

  // Events: new pending request per slot, and service acknowledge
  wire logic [STATUS_W-1:0] evt;
  assign evt[NUM_SLOTS-1:0] = pend & ~pend_q;
  assign evt[EVT_ACK_BIT]   = (state == ST_PRESENT) & vector_ack;

  // Write-one-to-clear; a new event in the same cycle wins
  wire logic [STATUS_W-1:0] status_clr = (wr && hit_status) ? pwdata[STATUS_W-1:0]
                                                            : STATUS_RESET;

  // Status, mask and interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
      status <= STATUS_RESET;
      mask   <= MASK_RESET;
      irq    <= 1'b0;
    end else begin
      pend_q <= pend;
      status <= (status & ~status_clr) | evt;
      if (wr && hit_mask) begin
        mask <= pwdata[STATUS_W-1:0];
      end
      irq <= |(status & mask);
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reserved_zero: assert property (
    (setup && !pwrite && |hit_slot) |=> (prdata[31:CFG_W] == PAD_CFG))
    else $error("reserved slot bits read nonzero");

  a_base_write: assert property (
    (wr && hit_slot[0] && alias_sel == ALIAS_BASE)
      |=> (cfg[0] == $past(pwdata[CFG_W-1:0])))
    else $error("base write did not store data");

  a_set_alias: assert property (
    (wr && hit_slot[1] && alias_sel == ALIAS_SET)
      |=> (cfg[1] == ($past(cfg[1]) | $past(pwdata[CFG_W-1:0]))))
    else $error("set alias did not OR bits");

  a_clr_alias: assert property (
    (wr && hit_slot[0] && alias_sel == ALIAS_CLR)
      |=> (cfg[0] == ($past(cfg[0]) & ~$past(pwdata[CFG_W-1:0]))))
    else $error("clear alias did not clear bits");

  a_tog_alias: assert property (
    (wr && hit_slot[0] && alias_sel == ALIAS_TOG)
      |=> (cfg[0] == ($past(cfg[0]) ^ $past(pwdata[CFG_W-1:0]))))
    else $error("toggle alias did not invert bits");

  a_fast_route: assert property (
    (cfg[1].fast_steer && cfg[1].enable && (hw_source[1] || cfg[1].software_request))
      |=> fast_interrupt_line)
    else $error("fast steered request missing on fast line");

  // A write may enable a source at the sampled edge, so only a quiet start is checked
  a_enable_gate: assert property (
    (!cfg[0].enable && !cfg[1].enable && !vector_request)
      |=> (!fast_interrupt_line && !vector_request))
    else $error("disabled sources still requested");

  a_soft_vectored: assert property (
    (state == ST_IDLE && cfg[0].software_request && cfg[0].enable && !cfg[0].fast_steer)
      |=> vector_request)
    else $error("forced vectored request not presented");

  a_fast_bypass: assert property (
    ((|fast_cand) && !(|vec_cand) && state == ST_IDLE) |=> !vector_request)
    else $error("fast steered source presented as vector");

  // Service leaves two quiet cycles, ACKED then IDLE, before any new presentation
  a_ack_quiet: assert property (
    (vector_request && vector_ack) |=> !vector_request)
    else $error("request not withdrawn after acknowledge");

  // Unmapped writes must leave every slot untouched
  a_unmapped_write: assert property (
    (wr && !map_hit) |=> (cfg[0] == $past(cfg[0]) && cfg[1] == $past(cfg[1])))
    else $error("unmapped write altered a slot");

  a_level_order: assert property (
    (vec_cand == 2'h3 && cfg[1].level > cfg[0].level && next_state == ST_PRESENT)
      |=> (vector_out.source && vector_out.level == $past(cfg[1].level)))
    else $error("weaker source won arbitration");

  a_irq_level: assert property (
    $rose(irq) |-> $past(|(status & mask)))
    else $error("interrupt raised without unmasked event");

  c_fast_line:   cover property ($rose(fast_interrupt_line));
  c_vector_ack:  cover property (vector_request && vector_ack);
  c_both_vector: cover property (vec_cand == 2'h3 && vector_request);
  c_unmapped:    cover property (pslverr);

endmodule : irq_source_config_slots
`default_nettype wire
